// ===== rtl/scp_pkg.sv
`default_nettype none
package scp_pkg;
	localparam int CLK_HZ = 25000000;
	localparam int BAUD_BPS = 9600;
	// One bit time in clocks, rounded down, loaded as count minus one
	localparam logic [11:0] BIT_CYC = 12'(CLK_HZ / BAUD_BPS);
	localparam logic [11:0] HALF_CYC = 12'(CLK_HZ / BAUD_BPS / 2);
	localparam int DATA_BITS = 8;
	localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_DOT = 8'h2E;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_UP_A = 8'h41;
	localparam logic [7:0] CH_UP_Z = 8'h5A;
	localparam logic [7:0] CH_LO_A = 8'h61;
	localparam logic [7:0] CH_LO_Z = 8'h7A;
	localparam logic [7:0] CASE_BIT = 8'h20;

	typedef enum logic [1:0] {
		SCP_TERM_CR = 2'h0,
		SCP_TERM_LF = 2'h1,
		SCP_TERM_CRLF = 2'h2
	} scp_term_e;

	typedef enum logic [1:0] {
		SCP_LN_IDLE = 2'h0,
		SCP_LN_START = 2'h1,
		SCP_LN_DATA = 2'h3,
		SCP_LN_STOP = 2'h2
	} scp_line_e;

	localparam int NUM_CMDS = 16;
	localparam logic [15:0] CMD_TABLE [NUM_CMDS] = '{
		16'h4355, 16'h544C, 16'h5741, 16'h414F, 16'h4146, 16'h5355, 16'h4F50, 16'h4C50,
		16'h434F, 16'h4346, 16'h4356, 16'h4C4F, 16'h4C46, 16'h4449, 16'h4654, 16'h4154
	};
	// Commands that also pick the output variable
	localparam logic [NUM_CMDS-1:0] SELECTS_OUTPUT = 16'hC4E7;
	localparam logic [15:0] DATA_FETCH_CMD = 16'h4449;
	localparam logic [15:0] STATUS_QUERY_CMD = 16'h5355;
	localparam logic [15:0] NOT_RECOGNIZED_REPLY = 16'h4E52;
	localparam logic [15:0] OUT_SEL_RESET = 16'h0000;
endpackage : scp_pkg
`default_nettype wire

// ===== rtl/scp_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module scp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb
	begin
		next_wr_ptr = push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
		next_rd_ptr = pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage needs no reset; reads are gated by count
	always_ff @(posedge clock_i)
	begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
endmodule : scp_fifo
`default_nettype wire

// ===== rtl/scp_serial_command_port.sv
// Functional notes
// - Fixed 9600 bps, 8N1, no flow control
// - Two letters, case folded to one command
// - Valid command echoes its two letters back
// - Unknown command replies NR instead
// - Data fetch command answers data, no echo
// - Terminator is CR, LF or CR LF
// - Echo only on serial, never data fetch
// - SELECTS_OUTPUT commands select output, bare or with a number
// - Status query gives no echo either
// - Output selection holds until changed
`timescale 1ns/10ps
`default_nettype none
module scp_serial_command_port (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ttl_serial_in_i,
	input wire logic line_level_serial_in_i,
	output logic ttl_serial_out_o,
	output logic line_level_serial_out_o,
	input wire logic [1:0] term_sel_i,
	output logic cmd_valid_o,
	output logic [15:0] cmd_code_o,
	output logic cmd_has_data_o,
	output logic cmd_neg_o,
	output logic [31:0] cmd_data_o,
	output logic [15:0] out_sel_o,
	output logic fetch_req_o,
	input wire logic reply_valid_i,
	input wire logic [7:0] reply_data_i,
	output logic reply_ready_o,
	output logic overrun_o
);
	// Both line levels are wired onto one receiver; an unused one idles high
	logic serial_in;
	assign serial_in = ttl_serial_in_i & line_level_serial_in_i;

	// Receiver
	scp_pkg::scp_line_e rx_st, next_rx_st;
	logic [11:0] rx_cnt, next_rx_cnt;
	logic [2:0] rx_bit, next_rx_bit;
	logic [7:0] rx_sh, next_rx_sh;
	logic rx_push, next_rx_push;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [7:0] fifo_byte;

	always_comb
	begin
		next_rx_st = rx_st;
		next_rx_cnt = rx_cnt - 12'h001;
		next_rx_bit = rx_bit;
		next_rx_sh = rx_sh;
		next_rx_push = 1'b0;
		unique case (rx_st)
			scp_pkg::SCP_LN_IDLE:
			begin
				next_rx_cnt = scp_pkg::HALF_CYC;
				if (!serial_in)
					next_rx_st = scp_pkg::SCP_LN_START;
			end
			scp_pkg::SCP_LN_START:
				if (rx_cnt == 12'h000)
				begin
					next_rx_cnt = scp_pkg::BIT_CYC - 12'h001;
					next_rx_bit = 3'h0;
					next_rx_st = serial_in ? scp_pkg::SCP_LN_IDLE : scp_pkg::SCP_LN_DATA;
				end
			scp_pkg::SCP_LN_DATA:
				if (rx_cnt == 12'h000)
				begin
					next_rx_cnt = scp_pkg::BIT_CYC - 12'h001;
					next_rx_sh = {serial_in, rx_sh[7:1]};
					next_rx_bit = rx_bit + 3'h1;
					if (rx_bit == scp_pkg::LAST_BIT)
						next_rx_st = scp_pkg::SCP_LN_STOP;
				end
			scp_pkg::SCP_LN_STOP:
				if (rx_cnt == 12'h000)
				begin
					// A broken stop bit drops the frame
					next_rx_push = serial_in;
					next_rx_st = scp_pkg::SCP_LN_IDLE;
				end
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rx_st <= scp_pkg::SCP_LN_IDLE;
			{rx_cnt, rx_bit, rx_sh, rx_push, overrun_o} <= '0;
		end
		else
		begin
			rx_st <= next_rx_st;
			{rx_cnt, rx_bit, rx_sh, rx_push} <= {next_rx_cnt, next_rx_bit, next_rx_sh, next_rx_push};
			// No flow control exists, so a full buffer loses the byte
			overrun_o <= rx_push && !fifo_in_ready;
		end
	end

	scp_fifo #(
		.WIDTH(scp_pkg::FIFO_WIDTH),
		.DEPTH(scp_pkg::FIFO_DEPTH)
	) u_rx_fifo (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.in_valid_i(rx_push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(rx_sh),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_byte)
	);

	// Command parser
	logic [1:0] nchar, next_nchar;
	logic [7:0] c0, c1, next_c0, next_c1;
	logic has_data, next_has_data, neg, next_neg, bad, next_bad, cr_seen, next_cr_seen;
	logic [31:0] val, next_val;
	logic echo_pend, next_echo_pend;
	logic [15:0] echo_code, next_echo_code;
	logic [1:0] echo_step, next_echo_step;
	logic next_cmd_valid, next_cmd_has_data, next_cmd_neg, next_fetch_req;
	logic [15:0] next_cmd_code, next_out_sel;
	logic [31:0] next_cmd_data;
	logic pop, is_term, found, sel_hit, tx_load, echo_last;
	logic [7:0] up;
	logic [15:0] code;

	// Parsing halts while an echo is owed, so the buffer fills behind it
	assign fifo_out_ready = !echo_pend;
	assign pop = fifo_out_valid && fifo_out_ready;

	always_comb
	begin
		up = fifo_byte;
		if (fifo_byte >= scp_pkg::CH_LO_A && fifo_byte <= scp_pkg::CH_LO_Z)
			up = fifo_byte & ~scp_pkg::CASE_BIT;
		code = {c0, c1};
		found = 1'b0;
		sel_hit = 1'b0;
		for (int i = 0; i < scp_pkg::NUM_CMDS; i++)
		begin
			if (code == scp_pkg::CMD_TABLE[i])
			begin
				found = 1'b1;
				sel_hit = scp_pkg::SELECTS_OUTPUT[i];
			end
		end
		found = found && (nchar == 2'h2) && !bad;
		unique case (term_sel_i)
			2'(scp_pkg::SCP_TERM_CR): is_term = (fifo_byte == scp_pkg::CH_CR);
			2'(scp_pkg::SCP_TERM_LF): is_term = (fifo_byte == scp_pkg::CH_LF);
			default: is_term = (fifo_byte == scp_pkg::CH_LF) && cr_seen;
		endcase
		next_nchar = nchar;
		next_c0 = c0;
		next_c1 = c1;
		next_has_data = has_data;
		next_neg = neg;
		next_bad = bad;
		next_val = val;
		next_cr_seen = pop ? (fifo_byte == scp_pkg::CH_CR) : cr_seen;
		next_echo_pend = echo_pend;
		next_echo_code = echo_code;
		next_cmd_valid = 1'b0;
		next_fetch_req = 1'b0;
		next_cmd_code = cmd_code_o;
		next_cmd_has_data = cmd_has_data_o;
		next_cmd_neg = cmd_neg_o;
		next_cmd_data = cmd_data_o;
		next_out_sel = out_sel_o;
		if (pop && is_term)
		begin
			if (nchar != 2'h0)
			begin
				next_cmd_valid = found;
				if (found)
				begin
					next_cmd_code = code;
					next_cmd_has_data = has_data;
					next_cmd_neg = neg;
					next_cmd_data = val;
					next_fetch_req = (code == scp_pkg::DATA_FETCH_CMD);
				end
				if (found && sel_hit)
					next_out_sel = code;
				next_echo_code = found ? code : scp_pkg::NOT_RECOGNIZED_REPLY;
				next_echo_pend = !(found && (code == scp_pkg::DATA_FETCH_CMD
					|| code == scp_pkg::STATUS_QUERY_CMD));
			end
			next_nchar = 2'h0;
			next_has_data = 1'b0;
			next_neg = 1'b0;
			next_bad = 1'b0;
			next_val = 32'h00000000;
		end
		else if (pop && fifo_byte != scp_pkg::CH_CR && fifo_byte != scp_pkg::CH_LF)
		begin
			if (nchar != 2'h2)
			begin
				if (up < scp_pkg::CH_UP_A || up > scp_pkg::CH_UP_Z)
					next_bad = 1'b1;
				if (nchar == 2'h0)
					next_c0 = up;
				else
					next_c1 = up;
				next_nchar = nchar + 2'h1;
			end
			else if (fifo_byte >= scp_pkg::CH_ZERO && fifo_byte <= scp_pkg::CH_NINE)
			begin
				// Decimal point is dropped; the field format fixes its place
				next_val = 32'(val * 32'd10) + 32'(fifo_byte - scp_pkg::CH_ZERO);
				next_has_data = 1'b1;
			end
			else if (fifo_byte == scp_pkg::CH_MINUS && !has_data)
				next_neg = 1'b1;
			else if (fifo_byte != scp_pkg::CH_DOT && fifo_byte != scp_pkg::CH_PLUS
				&& fifo_byte != scp_pkg::CH_SPACE)
				next_bad = 1'b1;
		end
		if (echo_pend && tx_load && echo_last)
			next_echo_pend = 1'b0;
	end

	// Transmitter and echo sequencer
	scp_pkg::scp_line_e tx_st, next_tx_st;
	logic [11:0] tx_cnt, next_tx_cnt;
	logic [2:0] tx_bit, next_tx_bit;
	logic [7:0] tx_sh, next_tx_sh, tx_byte;
	logic tx_line, next_tx_line;

	always_comb
	begin
		echo_last = (echo_step == 2'h3)
			|| (echo_step == 2'h2 && term_sel_i != 2'(scp_pkg::SCP_TERM_CRLF));
		unique case (echo_step)
			2'h0: tx_byte = echo_code[15:8];
			2'h1: tx_byte = echo_code[7:0];
			2'h2: tx_byte = (term_sel_i == 2'(scp_pkg::SCP_TERM_LF)) ? scp_pkg::CH_LF
				: scp_pkg::CH_CR;
			default: tx_byte = scp_pkg::CH_LF;
		endcase
		if (!echo_pend)
			tx_byte = reply_data_i;
		// Echo wins the line over fetched data
		reply_ready_o = (tx_st == scp_pkg::SCP_LN_IDLE) && !echo_pend;
		tx_load = (tx_st == scp_pkg::SCP_LN_IDLE) && (echo_pend || reply_valid_i);
		next_echo_step = echo_step;
		if (tx_load && echo_pend)
			next_echo_step = echo_last ? 2'h0 : echo_step + 2'h1;
		next_tx_st = tx_st;
		next_tx_cnt = tx_cnt - 12'h001;
		next_tx_bit = tx_bit;
		next_tx_sh = tx_sh;
		next_tx_line = tx_line;
		unique case (tx_st)
			scp_pkg::SCP_LN_IDLE:
				if (tx_load)
				begin
					next_tx_sh = tx_byte;
					next_tx_line = 1'b0;
					next_tx_cnt = scp_pkg::BIT_CYC - 12'h001;
					next_tx_st = scp_pkg::SCP_LN_START;
				end
			scp_pkg::SCP_LN_START:
				if (tx_cnt == 12'h000)
				begin
					next_tx_line = tx_sh[0];
					next_tx_bit = 3'h0;
					next_tx_cnt = scp_pkg::BIT_CYC - 12'h001;
					next_tx_st = scp_pkg::SCP_LN_DATA;
				end
			scp_pkg::SCP_LN_DATA:
				if (tx_cnt == 12'h000)
				begin
					next_tx_cnt = scp_pkg::BIT_CYC - 12'h001;
					next_tx_bit = tx_bit + 3'h1;
					next_tx_sh = {1'b0, tx_sh[7:1]};
					next_tx_line = tx_sh[1];
					if (tx_bit == scp_pkg::LAST_BIT)
					begin
						next_tx_line = 1'b1;
						next_tx_st = scp_pkg::SCP_LN_STOP;
					end
				end
			scp_pkg::SCP_LN_STOP:
				if (tx_cnt == 12'h000)
					next_tx_st = scp_pkg::SCP_LN_IDLE;
		endcase
	end

	assign ttl_serial_out_o = tx_line;
	assign line_level_serial_out_o = tx_line;

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			{nchar, c0, c1, has_data, neg, bad, cr_seen, val} <= '0;
			{echo_pend, echo_code, echo_step} <= '0;
			{cmd_valid_o, cmd_code_o, cmd_has_data_o, cmd_neg_o, cmd_data_o} <= '0;
			out_sel_o <= scp_pkg::OUT_SEL_RESET;
			fetch_req_o <= 1'b0;
			tx_st <= scp_pkg::SCP_LN_IDLE;
			{tx_cnt, tx_bit, tx_sh} <= '0;
			tx_line <= 1'b1;
		end
		else
		begin
			{nchar, c0, c1, has_data, neg, bad, cr_seen, val} <= {next_nchar, next_c0,
				next_c1, next_has_data, next_neg, next_bad, next_cr_seen, next_val};
			{echo_pend, echo_code, echo_step} <= {next_echo_pend, next_echo_code,
				next_echo_step};
			{cmd_valid_o, cmd_code_o, cmd_has_data_o, cmd_neg_o, cmd_data_o} <= {next_cmd_valid,
				next_cmd_code, next_cmd_has_data, next_cmd_neg, next_cmd_data};
			out_sel_o <= next_out_sel;
			fetch_req_o <= next_fetch_req;
			tx_st <= next_tx_st;
			{tx_cnt, tx_bit, tx_sh, tx_line} <= {next_tx_cnt, next_tx_bit, next_tx_sh, next_tx_line};
		end
	end
endmodule : scp_serial_command_port
`default_nettype wire

// ===== sim/scp_checker_sva.sv
`timescale 1ns/10ps
`default_nettype none
module scp_checker_sva (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ttl_serial_out_o,
	input wire logic line_level_serial_out_o,
	input wire logic cmd_valid_o,
	input wire logic [15:0] cmd_code_o,
	input wire logic [15:0] out_sel_o,
	input wire logic fetch_req_o,
	input wire logic reply_valid_i,
	input wire logic reply_ready_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	// Length of the current level on the transmit line, saturating
	logic tx_q;
	logic next_tx_q;
	logic [11:0] run;
	logic [11:0] next_run;
	always_comb
	begin
		next_tx_q = ttl_serial_out_o;
		next_run = (run == 12'hFFF) ? run : run + 12'h001;
		if (ttl_serial_out_o != tx_q)
			next_run = 12'h000;
	end
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tx_q <= 1'b1;
			run <= 12'h000;
		end
		else
		begin
			tx_q <= next_tx_q;
			run <= next_run;
		end
	end
	property p_bit_time;
		(ttl_serial_out_o != tx_q) |-> run >= scp_pkg::BIT_CYC - 12'h001;
	endproperty
	a_bit_time: assert property (p_bit_time) else $error("tx level too short");
	property p_lines_same;
		ttl_serial_out_o == line_level_serial_out_o;
	endproperty
	a_lines_same: assert property (p_lines_same) else $error("tx copies differ");
	property p_code_upper;
		cmd_valid_o |-> cmd_code_o[15:8] inside {[scp_pkg::CH_UP_A:scp_pkg::CH_UP_Z]}
			&& cmd_code_o[7:0] inside {[scp_pkg::CH_UP_A:scp_pkg::CH_UP_Z]};
	endproperty
	a_code_upper: assert property (p_code_upper) else $error("code not folded");
	property p_sel_hold;
		$changed(out_sel_o) |-> cmd_valid_o;
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("selection moved");
	property p_sel_code;
		$changed(out_sel_o) |-> out_sel_o == cmd_code_o;
	endproperty
	a_sel_code: assert property (p_sel_code) else $error("selection not code");
	property p_reply_start;
		reply_valid_i && reply_ready_o |=> !ttl_serial_out_o;
	endproperty
	a_reply_start: assert property (p_reply_start) else $error("reply not started");
	property p_busy;
		!ttl_serial_out_o |-> !reply_ready_o;
	endproperty
	a_busy: assert property (p_busy) else $error("ready while sending");
	property p_fetch_quiet;
		fetch_req_o ##1 !reply_valid_i [*4] |-> ttl_serial_out_o;
	endproperty
	a_fetch_quiet: assert property (p_fetch_quiet) else $error("fetch echoed");
endmodule : scp_checker_sva
`default_nettype wire

// ===== sim/scp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module scp_host_model (
	input wire logic clock_i,
	input wire logic rx_line_i,
	output logic tx_line_o
);
	// Only data lines exist; the host has no handshake lines
	logic [7:0] rx_q [$];
	logic [7:0] rx_byte;
	int j;
	initial tx_line_o = 1'b1;
	// 8N1, LSB first, fixed rate
	task automatic send_byte(input logic [7:0] b);
		int i;
		@(posedge clock_i);
		tx_line_o <= 1'b0;
		repeat (scp_pkg::BIT_CYC) @(posedge clock_i);
		for (i = 0; i < 8; i++)
		begin
			tx_line_o <= b[i];
			repeat (scp_pkg::BIT_CYC) @(posedge clock_i);
		end
		tx_line_o <= 1'b1;
		repeat (scp_pkg::BIT_CYC) @(posedge clock_i);
	endtask : send_byte
	task automatic send_str(input string s);
		int i;
		for (i = 0; i < s.len(); i++)
			send_byte(s[i]);
	endtask : send_str
	always
	begin
		@(negedge rx_line_i);
		repeat (scp_pkg::HALF_CYC) @(posedge clock_i);
		for (j = 0; j < 8; j++)
		begin
			repeat (scp_pkg::BIT_CYC) @(posedge clock_i);
			rx_byte[j] = rx_line_i;
		end
		repeat (scp_pkg::BIT_CYC) @(posedge clock_i);
		rx_q.push_back(rx_byte);
	end
endmodule : scp_host_model
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic host_line, tx_ttl, cmd_valid, has_data, fetch_req, reply_ready;
	logic tx_line_lvl, cmd_neg, overrun;
	logic use_line = 1'b0;
	logic [1:0] term_sel = 2'h0;
	logic reply_valid = 1'b0;
	logic [7:0] reply_data = 8'h00;
	logic [15:0] cmd_code, out_sel;
	logic [31:0] cmd_data;
	int miscompares = 0;
	int compares = 0;
	int n_valid = 0;
	int n_fetch = 0;
	int n_overrun = 0;
	always #20 clock_i = ~clock_i;
	// Host uses one line level at a time; the other input idles high
	scp_serial_command_port i_dut (.clock_i, .rstn_i,
		.ttl_serial_in_i(use_line ? 1'b1 : host_line),
		.line_level_serial_in_i(use_line ? host_line : 1'b1),
		.ttl_serial_out_o(tx_ttl), .line_level_serial_out_o(tx_line_lvl),
		.term_sel_i(term_sel), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
		.cmd_has_data_o(has_data), .cmd_neg_o(cmd_neg), .cmd_data_o(cmd_data), .out_sel_o(out_sel),
		.fetch_req_o(fetch_req), .reply_valid_i(reply_valid), .reply_data_i(reply_data),
		.reply_ready_o(reply_ready), .overrun_o(overrun));
	scp_host_model i_host (.clock_i, .rx_line_i(use_line ? tx_line_lvl : tx_ttl),
		.tx_line_o(host_line));
	always @(posedge clock_i)
	begin
		if (cmd_valid === 1'b1)
			n_valid++;
		if (fetch_req === 1'b1)
			n_fetch++;
		if (overrun === 1'b1)
			n_overrun++;
	end
	task stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	// The host waits for the whole echo before its next command
	task wait_rx(input int n);
		int k;
		for (k = 0; k < 120000 && i_host.rx_q.size() < n; k++)
			@(posedge clock_i);
		if (i_host.rx_q.size() < n)
		begin
			miscompares++;
			$display("wrong value reply count expected %0d seen %0d", n, i_host.rx_q.size());
			stop_test();
		end
	endtask : wait_rx
	task check_rx(input logic [7:0] b);
		logic [7:0] got;
		got = i_host.rx_q.pop_front();
		`CHK("reply byte", b, got)
	endtask : check_rx
	task s_set_value;
		@(posedge clock_i);
		term_sel <= 2'h0;
		i_host.send_str("wA-15\r");
		wait_rx(3);
		`CHK("valid count", 1, n_valid)
		`CHK("code", 16'h5741, cmd_code)
		`CHK("has data", 1'b1, has_data)
		`CHK("negative", 1'b1, cmd_neg)
		`CHK("data", 32'h0000000F, cmd_data)
		`CHK("selection", 16'h5741, out_sel)
		check_rx(8'h57);
		check_rx(8'h41);
		check_rx(8'h0D);
	endtask : s_set_value
	// Runs over the second line level in both directions
	task s_unknown;
		@(posedge clock_i);
		term_sel <= 2'h1;
		use_line <= 1'b1;
		i_host.send_str("zz\n");
		wait_rx(3);
		`CHK("valid count", 1, n_valid)
		`CHK("selection", 16'h5741, out_sel)
		check_rx(8'h4E);
		check_rx(8'h52);
		check_rx(8'h0A);
	endtask : s_unknown
	task s_fetch;
		int k;
		@(posedge clock_i);
		term_sel <= 2'h2;
		use_line <= 1'b0;
		i_host.send_str("Su\r\n");
		i_host.send_str("Di\r\n");
		for (k = 0; k < 1000 && n_fetch == 0; k++)
			@(posedge clock_i);
		`CHK("fetch count", 1, n_fetch)
		`CHK("valid count", 3, n_valid)
		`CHK("selection", 16'h5355, out_sel)
		`CHK("echo count", 0, i_host.rx_q.size())
		// Late offer so a wrong echo would show first
		repeat (8) @(posedge clock_i);
		reply_valid <= 1'b1;
		reply_data <= 8'h37;
		k = 0;
		do
		begin
			@(negedge clock_i);
			k++;
		end
		while (reply_ready !== 1'b1 && k < 1000);
		`CHK("reply ready", 1'b1, reply_ready)
		// The byte is taken at the edge that samples ready high
		@(posedge clock_i);
		reply_valid <= 1'b0;
		wait_rx(1);
		check_rx(8'h37);
		`CHK("selection", 16'h5355, out_sel)
		`CHK("overrun count", 0, n_overrun)
	endtask : s_fetch
	initial
	begin
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		@(posedge clock_i);
		s_set_value();
		s_unknown();
		s_fetch();
		stop_test();
	end
endmodule : tb
bind scp_serial_command_port scp_checker_sva i_chk (.clock_i, .rstn_i, .ttl_serial_out_o,
	.line_level_serial_out_o, .cmd_valid_o, .cmd_code_o, .out_sel_o, .fetch_req_o,
	.reply_valid_i, .reply_ready_o);
`default_nettype wire
